// ==== bench/mem_model.sv ====
// mem_model: behavioural program and data memory on the loader memory port.
// assumes requests are held until ack and everything runs on core_clk.
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic        mem_space,
  input  wire logic [23:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic        erase_prog,
  input  wire logic        erase_data,
  input  wire logic        bad_rd,
  output logic             mem_ack,
  output logic      [7:0]  mem_rdata
);
  logic [7:0] pm [int];  // program space, absent entry reads erased
  logic [7:0] dm [int];  // data space
  logic [7:0] rd;        // byte picked for the next ack
  // random wait of zero or more cycles; rdata toggles when not acking so
  // a stale sample cannot look right by luck
  always @(posedge core_clk) begin
    if (srst) begin
      mem_ack <= 1'b0;
      mem_rdata <= 8'h5A;
    end else begin
      if (erase_prog) pm.delete();
      if (erase_data) dm.delete();
      if (mem_req && mem_ack && mem_we) begin
        if (mem_space) dm[mem_addr] = mem_wdata;
        else pm[mem_addr] = mem_wdata;
      end
      if (mem_req && !mem_ack && $urandom_range(1) == 0) begin
        if (mem_space) rd = dm.exists(mem_addr) ? dm[mem_addr] : 8'hFF;
        else rd = pm.exists(mem_addr) ? pm[mem_addr] : 8'hFF;
        mem_ack <= 1'b1;
        mem_rdata <= rd ^ {7'h00, bad_rd};  // corrupted only on command
      end else begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
      end
    end
  end
endmodule
`default_nettype wire

// ==== bench/test_serial_loader_packet_handler.sv ====
// test_serial_loader_packet_handler: host packets in, answers compared with
// a queue model; assumes mem_model answers the memory port.
`timescale 1ns/1ps
`default_nettype none
module test_serial_loader_packet_handler;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic        rx_valid = 1'b0;
  logic        rx_ready;
  logic [7:0]  rx_data = 8'h00;
  logic        tx_valid;
  logic        tx_ready = 1'b1;
  logic [7:0]  tx_data;
  logic        mem_req;
  logic        mem_we;
  logic        mem_space;
  logic [23:0] mem_addr;
  logic [7:0]  mem_wdata;
  logic        mem_ack;
  logic [7:0]  mem_rdata;
  logic        erase_prog;
  logic        erase_data;
  logic        cmd_valid;
  logic [7:0]  cmd_code;
  logic [7:0]  cmd_arg;
  logic [15:0] baud_div;
  logic        bad_rd = 1'b0;  // makes the memory lie on reads
  logic [7:0]  exp_q [$];      // expected answer bytes in order
  logic [7:0]  pmem [int];     // shadow of program space
  logic [7:0]  q [$];          // payload after the command byte
  logic [7:0]  last_cmd;
  logic [7:0]  last_arg;
  logic [7:0]  cmds [6] = '{8'h53, 8'h42, 8'h55, 8'h54, 8'h46, 8'h51};
  bit          pe = 1'b0;      // program space erased this session
  bit          de = 1'b0;      // data space erased
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          n_ep = 0, n_ed = 0, n_cv = 0;
  int          ex_ep = 0, ex_ed = 0, ex_cv = 0;
  int          n_cycle = 0;

  always #2 core_clk = ~core_clk;

  loader_packet u_loader_packet (
    .core_clk(core_clk), .srst(srst), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .mem_req(mem_req), .mem_we(mem_we), .mem_space(mem_space), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .erase_prog(erase_prog), .erase_data(erase_data), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_arg(cmd_arg), .baud_div(baud_div)
  );

  mem_model u_mem_model (
    .core_clk(core_clk), .srst(srst), .mem_req(mem_req), .mem_we(mem_we),
    .mem_space(mem_space), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .erase_prog(erase_prog), .erase_data(erase_data), .bad_rd(bad_rd),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata)
  );

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // receiver stalls at random so the answer buffer fills
  always @(posedge core_clk) #1 tx_ready = ($urandom_range(3) != 0);

  // answer bytes and pulses seen at the ports
  always @(posedge core_clk) begin
    n_cycle++;
    if (!srst && tx_valid && tx_ready) begin
      if (exp_q.size() == 0) check("tx extra", {8'h00, tx_data}, 16'hFFFF);
      else check("tx byte", {8'h00, tx_data}, {8'h00, exp_q.pop_front()});
    end
    if (erase_prog) n_ep++;
    if (erase_data) n_ed++;
    if (cmd_valid) n_cv++;
    if (cmd_valid) last_cmd = cmd_code;
    if (cmd_valid) last_arg = cmd_arg;
    if (n_cycle == 30000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  // one byte offered and held until the edge that takes it
  task automatic put(input logic [7:0] b);
    rx_valid = 1'b1;
    rx_data = b;
    while (rx_ready !== 1'b1) @(posedge core_clk) #1;
    @(posedge core_clk) #1;
  endtask

  // let the answer drain, then compare the pulse counts
  task automatic drain();
    int k;
    rx_valid = 1'b0;
    rx_data = ~rx_data;
    k = 0;
    while (exp_q.size() != 0 && k < 3000) begin
      @(posedge core_clk);
      k++;
    end
    if (k == 3000) check("answer wait", 16'h0000, 16'h0001);
    repeat (4) @(posedge core_clk);
    #1;
    check("erase_prog", 16'(n_ep), 16'(ex_ep));
    check("erase_data", 16'(n_ed), 16'(ex_ed));
    check("cmd pulses", 16'(n_cv), 16'(ex_cv));
  endtask

  // host side of one packet plus the expected answer
  task automatic send(input logic [7:0] cmd, input logic [7:0] d[$], input bit bad);
    logic [7:0] sum;
    logic [7:0] cs;
    logic [7:0] b;
    int         n;
    int         a;
    bit         ok;
    bit         quiet;
    n = d.size() + 1;
    sum = 8'(n) + cmd;
    foreach (d[i]) sum += d[i];
    ok = 1'b0;
    quiet = 1'b0;
    a = 0;
    cs = 8'h00;
    if (!bad) case (cmd)
      8'h41, 8'h43: begin
        ok = (n == 1);
        if (ok) begin
          pe = 1'b1;
          ex_ep++;
          pmem.delete();
        end
        if (ok && cmd == 8'h41) begin
          de = 1'b1;
          ex_ed++;
        end
      end
      8'h57, 8'h45: begin
        ok = ((cmd == 8'h57) ? pe : de) && n >= 4 && !bad_rd;
        if (n >= 4) a = {8'h00, d[0], d[1], d[2]};
        for (int i = 3; ok && cmd == 8'h57 && i < d.size(); i++) pmem[a + i - 3] = d[i];
      end
      8'h56: begin
        if (pe && n == 2) begin
          quiet = 1'b1;
          a = d[0] * 256;
          for (int i = 0; i < 256; i++) begin
            b = pmem.exists(a + i) ? pmem[a + i] : 8'hFF;
            exp_q.push_back(b);
            cs += b;
          end
          exp_q.push_back(8'h00 - cs);
        end
      end
      8'h53, 8'h42, 8'h55, 8'h54, 8'h46: begin
        ok = 1'b1;
        ex_cv++;
      end
      default: ok = 1'b0;  // unknown code, page load refused too
    endcase
    if (!quiet) exp_q.push_back(ok ? 8'h06 : 8'h07);
    put(8'h07);
    put(8'h0E);
    put(8'(n));
    put(cmd);
    foreach (d[i]) put(d[i]);
    put((8'h00 - sum) ^ {7'h00, bad});
    drain();
  endtask

  initial begin
    void'($urandom(32'h63E16D46));
    repeat (2) @(posedge core_clk);
    #1 srst = 1'b0;
    check("baud_div", baud_div, 16'h65B9);
    // loader idle and listening before the first packet goes out
    check("rx_ready", {15'h0000, rx_ready}, 16'h0001);
    check("tx_valid", {15'h0000, tx_valid}, 16'h0000);
    // noise and a doubled first start byte ahead of the first packet
    put(8'h33);
    put(8'h0E);
    put(8'h07);
    q = {8'h00, 8'h00, 8'h10, 8'hAA};
    send(8'h57, q, 1'b0);
    q = {8'h00};
    send(8'h56, q, 1'b0);
    q = {};
    send(8'h43, q, 1'b1);
    // count zero and count one past the limit
    for (int c = 0; c < 2; c++) begin
      put(8'h07);
      put(8'h0E);
      put(c == 0 ? 8'h00 : 8'h1A);
      exp_q.push_back(8'h07);
      drain();
    end
    q = {8'h01};
    send(8'h41, q, 1'b0);
    q = {};
    send(8'h58, q, 1'b0);
    send(8'h43, q, 1'b0);
    q = {8'h00, 8'h00, 8'h01, 8'h22};
    send(8'h45, q, 1'b0);
    q = {8'h00, 8'h00, 8'hFE};
    repeat (21) q.push_back(8'($urandom));
    send(8'h57, q, 1'b0);  // full-length packet across a page edge
    q = {8'h00, 8'h00, 8'h10};
    send(8'h57, q, 1'b0);
    q = {8'h00};
    send(8'h56, q, 1'b0);
    q = {8'h01};
    send(8'h56, q, 1'b0);
    q = {};
    send(8'h41, q, 1'b0);
    q = {8'h00, 8'h00, 8'h05, 8'h0A, 8'h0B};
    send(8'h45, q, 1'b0);
    foreach (cmds[i]) begin
      q = {8'(i)};
      send(cmds[i], q, 1'b0);
      if (i < 5) check("cmd_code", {8'h00, last_cmd}, {8'h00, cmds[i]});
      if (i < 5) check("cmd_arg", {8'h00, last_arg}, {8'h00, 8'(i)});
    end
    bad_rd = 1'b1;
    q = {8'h00, 8'h02, 8'h00, 8'h5C, 8'h3D};
    send(8'h57, q, 1'b0);
    bad_rd = 1'b0;
    // a reset in mid-run forgets which spaces were erased
    srst = 1'b1;
    pe = 1'b0;
    de = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 srst = 1'b0;
    check("rx_ready", {15'h0000, rx_ready}, 16'h0001);
    q = {8'h00};
    send(8'h56, q, 1'b0);
    print_verdict();
  end
endmodule
`default_nettype wire

// ==== hdl/byte_fifo.sv ====
// byte_fifo: small valid/ready buffer for answer bytes.
// assumes both sides on core_clk; depth of two covers one stall.
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2,
  parameter int PW    = 1
) (
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  // whole state in one struct
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] slot;  // entries
    logic [PW-1:0]               wp;    // write pointer
    logic [PW-1:0]               rp;    // read pointer
    logic [PW:0]                 used;  // occupancy
  } fifo_s;

  fifo_s f_ff;
  fifo_s nxt_f;
  logic  push;
  logic  pop;

  // honest flags straight from occupancy
  assign in_ready  = (f_ff.used != (PW+1)'(DEPTH));
  assign out_valid = (f_ff.used != '0);
  assign out_data  = f_ff.slot[f_ff.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer wrap and occupancy update
  always_comb begin
    nxt_f = f_ff;
    if (push) begin
      nxt_f.slot[f_ff.wp] = in_data;
      nxt_f.wp = (f_ff.wp == PW'(DEPTH-1)) ? '0 : PW'(f_ff.wp + 1'b1);
    end
    if (pop) begin
      nxt_f.rp = (f_ff.rp == PW'(DEPTH-1)) ? '0 : PW'(f_ff.rp + 1'b1);
    end
    if (push && !pop) begin
      nxt_f.used = (PW+1)'(f_ff.used + 1'b1);
    end else if (pop && !push) begin
      nxt_f.used = (PW+1)'(f_ff.used - 1'b1);
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      f_ff <= '0;
    end else begin
      f_ff <= nxt_f;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/loader_packet.sv ====
// loader_packet: packet parser and command executor of the download loader.
// assumes a uart on core_clk hands received bytes over rx_valid/rx_ready and
// takes answer bytes from tx_valid/tx_ready; memory sits behind mem_req/mem_ack.
`timescale 1ns/1ps
`default_nettype none
module loader_packet #(
  parameter int TX_DEPTH = 2
) (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire logic [7:0]  rx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic      [7:0]  tx_data,
  output logic             mem_req,
  output logic             mem_we,
  output logic             mem_space,
  output logic      [23:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [7:0]  mem_rdata,
  output logic             erase_prog,
  output logic             erase_data,
  output logic             cmd_valid,
  output logic      [7:0]  cmd_code,
  output logic      [7:0]  cmd_arg,
  output logic      [15:0] baud_div
);
  // parser and executor states
  typedef enum logic [3:0] {
    HUNT, START2, COUNT, PAYLOAD, CSUM, EXEC, WR_FETCH, WR_GO,
    WR_WAIT, RB_WAIT, RD_REQ, RD_PUSH, SEND_CS, RESPOND
  } st_e;

  // whole state in one struct
  typedef struct packed {
    st_e         st;       // current state
    logic [4:0]  cnt;      // payload length
    logic [4:0]  idx;      // payload index
    logic [7:0]  sum;      // running checksum
    logic [7:0]  cmd;      // command byte
    logic [23:0] addr;     // memory address
    logic        er_prog;  // program space erased this session
    logic        er_data;  // data space erased this session
    logic [7:0]  resp;     // pending answer byte
    logic        req;      // memory request
    logic        we;       // memory write
    logic [7:0]  wdata;    // byte written or read
    logic [7:0]  nread;    // page bytes sent
    logic        ev;       // pass-through command strobe
    logic        e_prog;   // erase strobes
    logic        e_data;
  } st_s;
  st_s s_ff;
  st_s nxt_s;
  logic       ram_we;      // payload store write
  logic [7:0] ram_rdata;   // payload byte at idx
  logic       push_valid;  // answer byte offered
  logic       push_ready;  // answer buffer has room
  logic [7:0] push_data;   // answer byte
  logic       rx_take;     // byte consumed this cycle

  // true when the space addressed by cmd is erased
  function automatic logic space_ok(input logic [7:0] c, input logic ep, input logic ed);
    space_ok = (c == loader_pkg::CMD_PROG_DATA) ? ed : ep;
  endfunction
  payload_ram #(.WIDTH(8), .DEPTH(32), .AW(5)) u_ram (
    .core_clk (core_clk),
    .srst     (srst),
    .wr_en    (ram_we),
    .wr_addr  (s_ff.idx),
    .wr_data  (rx_data),
    .rd_addr  (s_ff.idx),
    .rd_data  (ram_rdata)
  );

  // answer path; a stalled uart backs up into the executor
  byte_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH), .PW(1)) u_txq (
    .core_clk  (core_clk),
    .srst      (srst),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );
  // receive only while parsing
  assign rx_ready = (s_ff.st inside {HUNT, START2, COUNT, PAYLOAD, CSUM});
  assign rx_take  = rx_valid && rx_ready;

  // parser, executor and answer sequencing
  always_comb begin
    nxt_s      = s_ff;
    nxt_s.ev     = 1'b0;
    nxt_s.e_prog = 1'b0;
    nxt_s.e_data = 1'b0;
    ram_we     = 1'b0;
    push_valid = 1'b0;
    push_data  = s_ff.resp;
    unique case (s_ff.st)
      HUNT: begin
        if (rx_take && rx_data == loader_pkg::START_FIRST) begin
          nxt_s.st = START2;
        end                   // anything else dropped
      end
      START2: begin
        if (rx_take) begin
          if (rx_data == loader_pkg::START_SECOND) begin
            nxt_s.st = COUNT;
          end else if (rx_data != loader_pkg::START_FIRST) begin
            nxt_s.st = HUNT;
          end
        end
      end
      COUNT: begin
        if (rx_take) begin
          nxt_s.sum  = rx_data;
          nxt_s.addr = '0;
          nxt_s.idx  = '0;
          if (rx_data == 8'h00 || rx_data > loader_pkg::MAX_COUNT) begin
            nxt_s.resp = loader_pkg::RESP_NAK;
            nxt_s.st   = RESPOND;
          end else begin
            nxt_s.cnt = rx_data[4:0];
            nxt_s.st  = PAYLOAD;
          end
        end
      end
      PAYLOAD: begin
        if (rx_take) begin
          ram_we    = 1'b1;
          nxt_s.sum = 8'(s_ff.sum + rx_data);
          if (s_ff.idx == 5'h00) begin
            nxt_s.cmd = rx_data;
          end else if (s_ff.idx < loader_pkg::ADDR_BYTES_END) begin
            nxt_s.addr = {s_ff.addr[15:0], rx_data};
          end
          nxt_s.idx = 5'(s_ff.idx + 5'h01);
          if (s_ff.idx == 5'(s_ff.cnt - 5'h01)) begin
            nxt_s.st = CSUM;
          end
        end
      end
      CSUM: begin
        if (rx_take) begin
          if (8'(s_ff.sum + rx_data) != 8'h00) begin
            nxt_s.resp = loader_pkg::RESP_NAK;
            nxt_s.st   = RESPOND;
          end else begin
            nxt_s.st = EXEC;
          end
        end
      end
      EXEC: begin
        nxt_s.resp = loader_pkg::RESP_NAK;  // default refusal
        nxt_s.st   = RESPOND;
        unique case (s_ff.cmd)
          loader_pkg::CMD_ERASE_ALL, loader_pkg::CMD_ERASE_PROG: begin
            if (s_ff.cnt == 5'h01) begin
              nxt_s.e_prog  = 1'b1;
              nxt_s.er_prog = 1'b1;
              if (s_ff.cmd == loader_pkg::CMD_ERASE_ALL) begin
                nxt_s.e_data  = 1'b1;
                nxt_s.er_data = 1'b1;
              end
              nxt_s.resp = loader_pkg::RESP_ACK;
            end
          end
          loader_pkg::CMD_PROG_CODE, loader_pkg::CMD_PROG_DATA: begin
            // unerased space or short header is refused
            if (space_ok(s_ff.cmd, s_ff.er_prog, s_ff.er_data) &&
                s_ff.cnt >= loader_pkg::ADDR_BYTES_END) begin
              if (s_ff.cnt == loader_pkg::ADDR_BYTES_END) begin
                nxt_s.resp = loader_pkg::RESP_ACK;  // nothing to write
              end else begin
                nxt_s.idx = loader_pkg::ADDR_BYTES_END;
                nxt_s.st  = WR_FETCH;
              end
            end
          end
          loader_pkg::CMD_READ_PAGE: begin
            // readback only of code erased in this session
            if (s_ff.er_prog && s_ff.cnt == loader_pkg::PAGE_CMD_COUNT) begin
              nxt_s.addr  = {8'h00, s_ff.addr[7:0], 8'h00};
              nxt_s.sum   = 8'h00;
              nxt_s.nread = 8'h00;
              nxt_s.req   = 1'b1;
              nxt_s.we    = 1'b0;
              nxt_s.st    = RD_REQ;
            end
          end
          loader_pkg::CMD_PAGE_LOAD: begin
            // a 256-byte page cannot fit a 25-byte packet: not supported
            nxt_s.resp = loader_pkg::RESP_NAK;
          end
          loader_pkg::CMD_SECURITY, loader_pkg::CMD_BAUD, loader_pkg::CMD_RUN_USER,
          loader_pkg::CMD_ERASE_TIME, loader_pkg::CMD_BOOT_EN: begin
            nxt_s.ev   = 1'b1;  // handed to the system logic
            nxt_s.resp = loader_pkg::RESP_ACK;
          end
          default: begin
            nxt_s.resp = loader_pkg::RESP_NAK;
          end
        endcase
      end
      WR_FETCH: begin
        nxt_s.st = WR_GO;  // ram read data lands next cycle
      end
      WR_GO: begin
        nxt_s.wdata = ram_rdata;
        nxt_s.req   = 1'b1;
        nxt_s.we    = 1'b1;
        nxt_s.st    = WR_WAIT;
      end
      WR_WAIT: begin
        if (mem_ack) begin
          nxt_s.we = 1'b0;  // request stays up for the read-back
          nxt_s.st = RB_WAIT;
        end
      end
      RB_WAIT: begin
        if (mem_ack) begin
          nxt_s.req = 1'b0;
          if (mem_rdata != s_ff.wdata) begin
            nxt_s.resp = loader_pkg::RESP_NAK;
            nxt_s.st   = RESPOND;
          end else if (s_ff.idx == 5'(s_ff.cnt - 5'h01)) begin
            nxt_s.resp = loader_pkg::RESP_ACK;
            nxt_s.st   = RESPOND;
          end else begin
            nxt_s.addr = 24'(s_ff.addr + 24'h000001);
            nxt_s.idx  = 5'(s_ff.idx + 5'h01);
            nxt_s.st   = WR_FETCH;
          end
        end
      end
      RD_REQ: begin
        if (mem_ack) begin
          nxt_s.wdata = mem_rdata;
          nxt_s.req   = 1'b0;
          nxt_s.st    = RD_PUSH;
        end
      end
      RD_PUSH: begin
        push_valid = 1'b1;
        push_data  = s_ff.wdata;
        if (push_ready) begin
          nxt_s.sum   = 8'(s_ff.sum + s_ff.wdata);
          nxt_s.addr  = 24'(s_ff.addr + 24'h000001);
          nxt_s.nread = 8'(s_ff.nread + 8'h01);
          if (s_ff.nread == loader_pkg::PAGE_LAST) begin
            nxt_s.st = SEND_CS;
          end else begin
            nxt_s.req = 1'b1;
            nxt_s.st  = RD_REQ;
          end
        end
      end
      SEND_CS: begin
        push_valid = 1'b1;
        push_data  = 8'(8'h00 - s_ff.sum);
        if (push_ready) begin
          nxt_s.st = HUNT;
        end
      end
      RESPOND: begin
        push_valid = 1'b1;
        if (push_ready) begin
          nxt_s.st = HUNT;
        end
      end
    endcase
  end

  // state register; erase flags clear only at reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_ff    <= '0;  // all-zero is the hunt state
    end else begin
      s_ff <= nxt_s;
    end
  end

  // outputs straight from flops except mem_space, decoded from cmd, and the constant baud_div
  assign mem_req    = s_ff.req;
  assign mem_we     = s_ff.we;
  assign mem_space  = (s_ff.cmd == loader_pkg::CMD_PROG_DATA);
  assign mem_addr   = s_ff.addr;
  assign mem_wdata  = s_ff.wdata;
  assign erase_prog = s_ff.e_prog;
  assign erase_data = s_ff.e_data;
  assign cmd_valid  = s_ff.ev;
  assign cmd_code   = s_ff.cmd;
  assign cmd_arg    = s_ff.addr[7:0];
  assign baud_div   = loader_pkg::BAUD_DIV;  // uart setting, 8N1
  // all checks below share the one core clock and its reset
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_hunt_discard: assert property (
    s_ff.st == HUNT && rx_valid && rx_data != loader_pkg::START_FIRST |=> s_ff.st == HUNT
  ) else $error("stray byte left hunt");
  a_start_pair: assert property (
    s_ff.st == COUNT && $past(s_ff.st) != COUNT |->
      $past(s_ff.st) == START2 && $past(rx_data) == loader_pkg::START_SECOND
  ) else $error("count entered without start pair");
  a_bad_count: assert property (
    s_ff.st == COUNT && rx_valid && (rx_data == 8'h00 || rx_data > 8'h19) |=>
      s_ff.st == RESPOND && s_ff.resp == 8'h07
  ) else $error("bad count not refused");
  a_csum_nak: assert property (
    s_ff.st == CSUM && rx_valid && 8'(s_ff.sum + rx_data) != 8'h00 |=>
      s_ff.st == RESPOND && s_ff.resp == 8'h07
  ) else $error("bad checksum not refused");
  a_erase_pair: assert property (
    erase_prog && s_ff.cmd == 8'h41 |-> erase_data ##1 s_ff.er_data && s_ff.er_prog
  ) else $error("erase all missed a space");
  a_erase_only: assert property (
    erase_prog |-> s_ff.cnt == 5'h01 && (s_ff.cmd == 8'h41 || !erase_data)
  ) else $error("erase with payload or wrong space");
  a_no_unerased: assert property (
    mem_req && mem_we |-> (mem_space ? s_ff.er_data : s_ff.er_prog)
  ) else $error("write to unerased space");
  a_verify_nak: assert property (
    s_ff.st == RB_WAIT && mem_ack && mem_rdata != mem_wdata |=>
      s_ff.resp == 8'h07 [*1] ##0 s_ff.st == RESPOND
  ) else $error("readback mismatch not refused");
  a_answer_code: assert property (
    push_valid && s_ff.st == RESPOND |-> push_data == 8'h06 || push_data == 8'h07
  ) else $error("answer is neither ack nor nak");
  a_page_len: assert property (
    s_ff.st == RD_PUSH && push_ready && s_ff.nread == 8'hFF |=> s_ff.st == SEND_CS
  ) else $error("page did not end after 256 bytes");
endmodule
`default_nettype wire

// ==== hdl/loader_pkg.sv ====
// loader_pkg: shared constants of the serial download packet handler.
// assumes one 250 MHz core clock and a byte-wide uart outside the block.
// Operation
// - packet opens with bytes 07h then 0Eh
// - count byte covers payload, legal 1 to 25
// - first payload byte is one of eleven commands
// - erase packets carry only the command byte
// - checksum makes count, payload, checksum sum zero
// - answer each packet with ack 06h or nak 07h; a served page read sends only its 256 bytes and checksum, no ack
// - checksum mismatch gets a nak
// - failed read-back after write gets a nak
// - programming an unerased space gets a nak
// - A erases program and data, C program only
// - link runs 9600 baud, 8 bits, no parity
// - program packet has 3-byte address, then increments
// - page read returns 256 bytes plus checksum
package loader_pkg;
  // framing bytes
  localparam logic [7:0] START_FIRST  = 8'h07;
  localparam logic [7:0] START_SECOND = 8'h0E;
  localparam logic [7:0] MAX_COUNT    = 8'h19;   // 25 payload bytes
  // answers
  localparam logic [7:0] RESP_ACK     = 8'h06;
  localparam logic [7:0] RESP_NAK     = 8'h07;
  // command codes
  localparam logic [7:0] CMD_ERASE_PROG = 8'h43; // C
  localparam logic [7:0] CMD_ERASE_ALL  = 8'h41; // A
  localparam logic [7:0] CMD_PROG_CODE  = 8'h57; // W
  localparam logic [7:0] CMD_READ_PAGE  = 8'h56; // V
  localparam logic [7:0] CMD_PAGE_LOAD  = 8'h51; // Q
  localparam logic [7:0] CMD_PROG_DATA  = 8'h45; // E
  localparam logic [7:0] CMD_SECURITY   = 8'h53; // S
  localparam logic [7:0] CMD_BAUD       = 8'h42; // B
  localparam logic [7:0] CMD_RUN_USER   = 8'h55; // U
  localparam logic [7:0] CMD_ERASE_TIME = 8'h54; // T
  localparam logic [7:0] CMD_BOOT_EN    = 8'h46; // F
  // payload layout
  localparam logic [4:0] ADDR_BYTES_END = 5'h04; // first data byte index
  localparam logic [4:0] PAGE_CMD_COUNT = 5'h02;
  localparam logic [7:0] PAGE_LAST      = 8'hFF; // 256 bytes per page
  // link timing
  localparam int         CLK_HZ    = 250_000_000;
  localparam int         BAUD_RATE = 9600;
  localparam logic [15:0] BAUD_DIV = 16'(CLK_HZ / BAUD_RATE);
  localparam int         DATA_BITS = 8;
  localparam logic       PARITY_ON = 1'b0;
endpackage

// ==== hdl/payload_ram.sv ====
// payload_ram: small store for the payload bytes of one packet.
// assumes a single writer and a registered read port on core_clk.
`timescale 1ns/1ps
`default_nettype none
module payload_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  // whole state in one struct
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;   // storage
    logic [WIDTH-1:0]            rd;    // registered read data
  } ram_s;

  ram_s ram_ff;
  ram_s nxt_ram;

  // write and read next state
  always_comb begin
    nxt_ram = ram_ff;
    if (wr_en) begin
      nxt_ram.mem[wr_addr] = wr_data;
    end
    nxt_ram.rd = ram_ff.mem[rd_addr];  // old data on same-address write
  end

  // clear on reset so no x reaches the checker
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ram_ff <= '0;
    end else begin
      ram_ff <= nxt_ram;
    end
  end

  assign rd_data = ram_ff.rd;
endmodule
`default_nettype wire
